// File: core/led_status_pkg.sv
// constants, types and register map of the light curtain status indicator encoder
package led_status_pkg;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_HZ             = 25_000_000;
  localparam int FLASH_HALF_MS      = 250;
  localparam int FLASH_HALF_CYCLES  = (CLK_HZ / 1000) * FLASH_HALF_MS;
  localparam int ALIGN_LIMIT_S      = 3;
  localparam int ALIGN_LIMIT_CYCLES = CLK_HZ * ALIGN_LIMIT_S;

  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [3:0]  ADDR_CTRL   = 4'h0;
  localparam logic [3:0]  ADDR_STATUS = 4'h4;
  localparam logic [3:0]  ADDR_LEDS   = 4'h8;
  localparam logic [2:0]  CTRL_RESET  = 3'h0;
  localparam int          CTRL_FEEDBACK_BIT  = 0;
  localparam int          CTRL_CODING_BIT    = 1;
  localparam int          CTRL_INTERLOCK_BIT = 2;
  localparam int          CTRL_HIDE_BIT      = 3;
  localparam int          STAT_ALIGN_BIT     = 0;
  localparam int          STAT_FAULT_BIT     = 1;
  localparam int          STAT_CABLED_BIT    = 2;
  localparam int          STAT_BLINK_BIT     = 3;
  localparam int          LEDS_PROT_POS      = 0;
  localparam int          LEDS_FIELD_POS     = 4;
  localparam int          LEDS_STATE_POS     = 8;
  localparam int          LEDS_SFIELD_POS    = 12;
  localparam logic [31:0] DATA_ZERO          = 32'h0000_0000;

  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [2:0] {
    COL_OFF          = 3'h0,
    COL_RED          = 3'h1,
    COL_GREEN        = 3'h2,
    COL_YELLOW       = 3'h3,
    COL_WHITE        = 3'h4,
    COL_BLUE         = 3'h5,
    COL_YELLOW_GREEN = 3'h6
  } colour_type;

  typedef struct packed {
    colour_type colour;
    logic       flash;
  } led_type;

  localparam led_type LED_DARK = '{colour: COL_OFF, flash: 1'b0};

endpackage : led_status_pkg

// File: core/light_curtain_status_leds.sv
// status and fault indication encoder for the sender and receiver leds
//
// Summary of operation
// - cabled sender shows the same status as the receiver in normal operation
// - cabled sender state led copies receiver protection output led colour and flash
// - uncabled, fault free sender outside factory restore and configuration mode shows yellow state led, field led off
// - feedback monitor configured with warning flashes diag led 1, leds 2-4 keep alignment
// - reset pushbutton error flashes diag led 4, leds 1-3 keep alignment
// - white diag leds show configured functions: 1 feedback, 3 coding, 4 interlock
// - factory restore: protection red, field yellow/green, all diag leds off
// - configuration mode: protection or state led red, field led green
// - laser aid on with field clear: protection red, field green
// - field interrupted, or clear with reset just pressed: protection and field red
// - field clear with reset pending: protection red, field yellow
// - defective or stuck reset pushbutton shows yellow on diag led 4
// - feedback input without signal: protection red, diag led 1 yellow
// - contamination rise, laser on or alignment over 3 s restore alignment display
// - sender supply failure: state yellow, field red flashing
// - sender internal fault: state yellow, field red flashing
// - failed factory restore: state green flashing, field red flashing
// - excessive supply voltage: state led off, field led red
// - diag leds 1-4 alignment, 5-6 top beam sync, 7-8 bottom beam sync
//
// The Wishbone interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps
module light_curtain_status_leds #(
  parameter int FLASH_CYCLES = led_status_pkg::FLASH_HALF_CYCLES,
  parameter int ALIGN_CYCLES = led_status_pkg::ALIGN_LIMIT_CYCLES
) (
  input  wire logic                          CLK,
  input  wire logic                          RST,
  input  wire logic                          CYC_I,
  input  wire logic                          STB_I,
  input  wire logic                          WE_I,
  input  wire logic [3:0]                    ADR_I,
  input  wire logic [3:0]                    SEL_I,
  input  wire logic [31:0]                   DAT_I,
  output logic      [31:0]                   DAT_O,
  output logic                               ACK_O,
  input  wire logic                          CABLED,
  input  wire logic                          FIELD_CLEAR,
  input  wire logic                          RESET_PENDING,
  input  wire logic                          RESET_PRESSED,
  input  wire logic                          LASER_ON,
  input  wire logic                          FACTORY_RESTORE,
  input  wire logic                          CONFIG_MODE,
  input  wire logic                          FEEDBACK_WARN,
  input  wire logic                          FEEDBACK_NO_SIGNAL,
  input  wire logic                          RESET_BTN_ERROR,
  input  wire logic                          RESET_BTN_DEFECT,
  input  wire logic [2:0]                    ALIGN_QUALITY,
  input  wire logic                          SYNC_TOP,
  input  wire logic                          SYNC_BOTTOM,
  input  wire logic                          CONTAMINATION_UP,
  input  wire logic                          ALIGNING,
  input  wire logic                          SUPPLY_FAIL,
  input  wire logic                          INTERNAL_FAULT,
  input  wire logic                          RESTORE_FAIL,
  input  wire logic                          OVERVOLTAGE,
  output led_status_pkg::colour_type         PROT_LED,
  output led_status_pkg::colour_type         FIELD_LED,
  output led_status_pkg::colour_type [7:0]   DIAG_LED,
  output led_status_pkg::colour_type         STATE_LED,
  output led_status_pkg::colour_type         SENDER_FIELD_LED
);

  // ************************************************************
  // wishbone slave
  // ************************************************************
  logic        ack_r;
  logic [31:0] dat_r;
  logic [2:0]  ctrl_r;
  logic [2:0]  ctrl_nxt;
  logic [31:0] rdata;
  logic [15:0] leds_word;
  wire         req        = CYC_I & STB_I;
  wire         wr_commit  = req & WE_I & ack_r & SEL_I[0];
  wire         sel_ctrl   = (ADR_I == led_status_pkg::ADDR_CTRL);
  wire         sel_status = (ADR_I == led_status_pkg::ADDR_STATUS);
  wire         sel_leds   = (ADR_I == led_status_pkg::ADDR_LEDS);
  wire         ctrl_wr    = wr_commit & sel_ctrl;
  wire         hide_req   = ctrl_wr & DAT_I[led_status_pkg::CTRL_HIDE_BIT];
  wire         fb_cfg     = ctrl_r[led_status_pkg::CTRL_FEEDBACK_BIT];
  wire         coding_cfg = ctrl_r[led_status_pkg::CTRL_CODING_BIT];
  wire         lock_cfg   = ctrl_r[led_status_pkg::CTRL_INTERLOCK_BIT];

  assign ctrl_nxt = ctrl_wr ? DAT_I[2:0] : ctrl_r;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ack_r  <= 1'b0;
      dat_r  <= led_status_pkg::DATA_ZERO;
      ctrl_r <= led_status_pkg::CTRL_RESET;
    end else begin
      ack_r  <= req & ~ack_r;
      dat_r  <= rdata;
      ctrl_r <= ctrl_nxt;
    end
  end

  assign ACK_O = ack_r;
  assign DAT_O = dat_r;

  // ************************************************************
  // flash divider and alignment timer
  // ************************************************************
  logic [31:0] flash_cnt_r;
  logic        blink_r;
  logic [31:0] align_cnt_r;
  logic        align_show_r;
  logic        align_show_nxt;
  logic        laser_q_r;
  logic        contam_q_r;
  wire         flash_tick  = (flash_cnt_r == 32'(FLASH_CYCLES - 1));
  wire         align_over  = ALIGNING & (align_cnt_r == 32'(ALIGN_CYCLES - 1));
  wire         resume_evt  = (LASER_ON & ~laser_q_r) | (CONTAMINATION_UP & ~contam_q_r) | align_over;

  // resume event wins over a software hide in the same cycle
  assign align_show_nxt = resume_evt ? 1'b1 : (hide_req ? 1'b0 : align_show_r);

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      flash_cnt_r  <= 32'h0000_0000;
      blink_r      <= 1'b1;
      align_cnt_r  <= 32'h0000_0000;
      align_show_r <= 1'b1;
      laser_q_r    <= 1'b0;
      contam_q_r   <= 1'b0;
    end else begin
      flash_cnt_r  <= flash_tick ? 32'h0000_0000 : flash_cnt_r + 32'h0000_0001;
      blink_r      <= flash_tick ? ~blink_r : blink_r;
      align_cnt_r  <= !ALIGNING ? 32'h0000_0000 : (align_over ? align_cnt_r : align_cnt_r + 32'h0000_0001);
      align_show_r <= align_show_nxt;
      laser_q_r    <= LASER_ON;
      contam_q_r   <= CONTAMINATION_UP;
    end
  end

  // ************************************************************
  // receiver protection output and field leds
  // ************************************************************
  led_status_pkg::led_type prot_nxt;
  led_status_pkg::led_type field_nxt;
  led_status_pkg::led_type prot_base;

  always_comb begin
    prot_base = '{colour: led_status_pkg::COL_GREEN, flash: 1'b0};
    field_nxt = '{colour: led_status_pkg::COL_GREEN, flash: 1'b0};
    if (FACTORY_RESTORE) begin
      prot_base = '{colour: led_status_pkg::COL_RED, flash: 1'b0};
      field_nxt = '{colour: led_status_pkg::COL_YELLOW_GREEN, flash: 1'b0};
    end else if (CONFIG_MODE) begin
      prot_base = '{colour: led_status_pkg::COL_RED, flash: 1'b0};
      field_nxt = '{colour: led_status_pkg::COL_GREEN, flash: 1'b0};
    end else if (LASER_ON && FIELD_CLEAR) begin
      prot_base = '{colour: led_status_pkg::COL_RED, flash: 1'b0};
      field_nxt = '{colour: led_status_pkg::COL_GREEN, flash: 1'b0};
    end else if (!FIELD_CLEAR || RESET_PRESSED) begin
      prot_base = '{colour: led_status_pkg::COL_RED, flash: 1'b0};
      field_nxt = '{colour: led_status_pkg::COL_RED, flash: 1'b0};
    end else if (RESET_PENDING) begin
      prot_base = '{colour: led_status_pkg::COL_RED, flash: 1'b0};
      field_nxt = '{colour: led_status_pkg::COL_YELLOW, flash: 1'b0};
    end
  end

  // a missing feedback signal forces the protection led red unless a factory restore runs
  assign prot_nxt = (FEEDBACK_NO_SIGNAL && !FACTORY_RESTORE) ?
                    '{colour: led_status_pkg::COL_RED, flash: 1'b0} : prot_base;

  // ************************************************************
  // receiver diagnostic leds
  // ************************************************************
  led_status_pkg::led_type [7:0] diag_nxt;

  always_comb begin
    diag_nxt = {8{led_status_pkg::LED_DARK}};
    if (align_show_r) begin
      for (int i = 0; i < 4; i++) begin
        if (ALIGN_QUALITY > 3'(i)) begin
          diag_nxt[i] = '{colour: led_status_pkg::COL_BLUE, flash: 1'b0};
        end
      end
      if (SYNC_TOP) begin
        diag_nxt[4] = '{colour: led_status_pkg::COL_BLUE, flash: 1'b0};
        diag_nxt[5] = '{colour: led_status_pkg::COL_BLUE, flash: 1'b0};
      end
      if (SYNC_BOTTOM) begin
        diag_nxt[6] = '{colour: led_status_pkg::COL_BLUE, flash: 1'b0};
        diag_nxt[7] = '{colour: led_status_pkg::COL_BLUE, flash: 1'b0};
      end
    end else begin
      if (fb_cfg) begin
        diag_nxt[0] = '{colour: led_status_pkg::COL_WHITE, flash: 1'b0};
      end
      if (coding_cfg) begin
        diag_nxt[2] = '{colour: led_status_pkg::COL_WHITE, flash: 1'b0};
      end
      if (lock_cfg) begin
        diag_nxt[3] = '{colour: led_status_pkg::COL_WHITE, flash: 1'b0};
      end
    end
    if (fb_cfg && FEEDBACK_WARN) begin
      diag_nxt[0] = '{colour: led_status_pkg::COL_YELLOW, flash: 1'b1};
    end
    if (RESET_BTN_ERROR) begin
      diag_nxt[3] = '{colour: led_status_pkg::COL_YELLOW, flash: 1'b1};
    end
    if (FEEDBACK_NO_SIGNAL) begin
      diag_nxt[0] = '{colour: led_status_pkg::COL_YELLOW, flash: 1'b0};
    end
    if (RESET_BTN_DEFECT) begin
      diag_nxt[3] = '{colour: led_status_pkg::COL_YELLOW, flash: 1'b0};
    end
    if (FACTORY_RESTORE) begin
      diag_nxt = {8{led_status_pkg::LED_DARK}};
    end
  end

  // ************************************************************
  // sender state and field leds
  // ************************************************************
  led_status_pkg::led_type state_nxt;
  led_status_pkg::led_type sfield_nxt;
  wire sender_fault = OVERVOLTAGE | RESTORE_FAIL | SUPPLY_FAIL | INTERNAL_FAULT;

  always_comb begin
    state_nxt  = '{colour: led_status_pkg::COL_YELLOW, flash: 1'b0};
    sfield_nxt = led_status_pkg::LED_DARK;
    if (OVERVOLTAGE) begin
      state_nxt  = led_status_pkg::LED_DARK;
      sfield_nxt = '{colour: led_status_pkg::COL_RED, flash: 1'b0};
    end else if (RESTORE_FAIL) begin
      state_nxt  = '{colour: led_status_pkg::COL_GREEN, flash: 1'b1};
      sfield_nxt = '{colour: led_status_pkg::COL_RED, flash: 1'b1};
    end else if (SUPPLY_FAIL || INTERNAL_FAULT) begin
      state_nxt  = '{colour: led_status_pkg::COL_YELLOW, flash: 1'b0};
      sfield_nxt = '{colour: led_status_pkg::COL_RED, flash: 1'b1};
    end else if (FACTORY_RESTORE || CONFIG_MODE || CABLED) begin
      // faults above take precedence over every mirrored indication
      state_nxt  = prot_nxt;
      sfield_nxt = field_nxt;
    end
  end

  // ************************************************************
  // flashing and output registers
  // ************************************************************
  function automatic led_status_pkg::colour_type shown(input led_status_pkg::led_type led, input logic on);
    shown = (led.flash && !on) ? led_status_pkg::COL_OFF : led.colour;
  endfunction : shown

  led_status_pkg::colour_type [7:0] diag_shown;

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      diag_shown[i] = shown(diag_nxt[i], blink_r);
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      PROT_LED         <= led_status_pkg::COL_OFF;
      FIELD_LED        <= led_status_pkg::COL_OFF;
      DIAG_LED         <= {8{led_status_pkg::COL_OFF}};
      STATE_LED        <= led_status_pkg::COL_OFF;
      SENDER_FIELD_LED <= led_status_pkg::COL_OFF;
    end else begin
      PROT_LED         <= shown(prot_nxt, blink_r);
      FIELD_LED        <= shown(field_nxt, blink_r);
      DIAG_LED         <= diag_shown;
      STATE_LED        <= shown(state_nxt, blink_r);
      SENDER_FIELD_LED <= shown(sfield_nxt, blink_r);
    end
  end

  // ************************************************************
  // read data
  // ************************************************************
  assign leds_word = {1'b0, SENDER_FIELD_LED, 1'b0, STATE_LED, 1'b0, FIELD_LED, 1'b0, PROT_LED};
  assign rdata = sel_ctrl   ? {29'h0000_0000, ctrl_r} :
                 sel_status ? {28'h000_0000, blink_r, CABLED, sender_fault, align_show_r} :
                 sel_leds   ? {16'h0000, leds_word} : led_status_pkg::DATA_ZERO;

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  wire quiet = !FACTORY_RESTORE && !CONFIG_MODE && !sender_fault;

  a_sender_mirror: assert property (CABLED && quiet |=> STATE_LED == PROT_LED)
    else $error("cabled sender state led differs from protection led");
  a_sender_field_mirror: assert property (CABLED && quiet |=> SENDER_FIELD_LED == FIELD_LED)
    else $error("cabled sender field led differs from receiver field led");
  a_sender_alone: assert property (!CABLED && quiet |=> STATE_LED == led_status_pkg::COL_YELLOW
    && SENDER_FIELD_LED == led_status_pkg::COL_OFF)
    else $error("uncabled sender not yellow with field off");
  a_factory_dark: assert property (FACTORY_RESTORE |=> DIAG_LED == {8{led_status_pkg::COL_OFF}}
    && PROT_LED == led_status_pkg::COL_RED && FIELD_LED == led_status_pkg::COL_YELLOW_GREEN)
    else $error("factory restore pattern wrong");
  a_config_mode: assert property (CONFIG_MODE && !FACTORY_RESTORE && !FEEDBACK_NO_SIGNAL
    |=> PROT_LED == led_status_pkg::COL_RED && FIELD_LED == led_status_pkg::COL_GREEN)
    else $error("configuration mode pattern wrong");
  a_field_broken: assert property (!FIELD_CLEAR && !FACTORY_RESTORE && !CONFIG_MODE
    |=> PROT_LED == led_status_pkg::COL_RED && FIELD_LED == led_status_pkg::COL_RED)
    else $error("interrupted field not shown red");
  a_reset_wait: assert property (FIELD_CLEAR && RESET_PENDING && !RESET_PRESSED && !LASER_ON
    && !FACTORY_RESTORE && !CONFIG_MODE |=> FIELD_LED == led_status_pkg::COL_YELLOW)
    else $error("pending reset not shown yellow");
  a_no_signal: assert property (FEEDBACK_NO_SIGNAL && !FACTORY_RESTORE
    |=> PROT_LED == led_status_pkg::COL_RED && DIAG_LED[0] == led_status_pkg::COL_YELLOW)
    else $error("missing feedback signal not indicated");
  a_overvolt: assert property (OVERVOLTAGE [*2] |=> STATE_LED == led_status_pkg::COL_OFF
    && SENDER_FIELD_LED == led_status_pkg::COL_RED)
    else $error("overvoltage pattern wrong");
  a_supply_fault: assert property ((SUPPLY_FAIL || INTERNAL_FAULT) && !OVERVOLTAGE && !RESTORE_FAIL
    |=> STATE_LED == led_status_pkg::COL_YELLOW && SENDER_FIELD_LED != led_status_pkg::COL_GREEN)
    else $error("sender fault pattern wrong");
  a_align_resume: assert property ($rose(LASER_ON) |=> align_show_r)
    else $error("alignment display not resumed");
  a_blink_step: assert property (flash_tick |=> blink_r != $past(blink_r))
    else $error("flash phase did not toggle");
  a_wb_ack: assert property (req && !ack_r |=> ack_r ##1 !ack_r)
    else $error("bus acknowledge not one cycle");

  c_mirror: cover property (CABLED && quiet ##1 PROT_LED == led_status_pkg::COL_RED);
  c_restore_fail: cover property (RESTORE_FAIL ##1 STATE_LED == led_status_pkg::COL_GREEN);
  c_hide_align: cover property (hide_req ##1 !align_show_r);
  c_feedback_flash: cover property (fb_cfg && FEEDBACK_WARN ##1 DIAG_LED[0] == led_status_pkg::COL_YELLOW);

endmodule : light_curtain_status_leds

// File: dv/led_viewer.sv
// partner model: an operator watching one indicator led over time
`timescale 1ns/1ps
module led_viewer (
  input  wire logic                       clk,
  input  wire logic                       clear,
  input  wire led_status_pkg::colour_type led,
  output logic                            seen_on,
  output logic                            seen_off,
  output led_status_pkg::colour_type      lit
);
  // ************************************************************
  // lit and dark history since the last clear
  // ************************************************************
  wire logic dark = (led == led_status_pkg::COL_OFF);
  always_ff @(posedge clk) begin
    seen_on  <= !clear && (seen_on || !dark);
    seen_off <= !clear && (seen_off || dark);
    if (!dark) begin
      lit <= led;
    end
  end
endmodule : led_viewer

// File: dv/test_light_curtain_status_leds.sv
// self-checking bench of the status indicator encoder
`timescale 1ns/1ps
module test_light_curtain_status_leds;
  // ************************************************************
  // stimulus, instances and scenarios
  // ************************************************************
  typedef struct packed {
    logic cabled, clr, pend, press, laser, fact, cfg, fwarn, fnosig, berr, bdef, top, bot, cont, algn, sfail,
      ifault, rfail, ovolt;
  } stat_type;
  localparam int FL = 4;
  localparam int AL = 20;
  logic                                  clk, rst, cyc, stb, we, ack, vclr;
  logic [3:0]                            adr, von, voff;
  logic [31:0]                           dat_w, dat_r, q;
  logic [2:0]                            qual;
  stat_type                              s;
  led_status_pkg::colour_type            prot, field, state, sfield;
  led_status_pkg::colour_type [7:0]      diag;
  led_status_pkg::colour_type [3:0]      vled, vlit;
  int                                    error_cnt, total_checks, cyc_cnt;
  assign vled = {diag[3], diag[0], state, sfield};
  light_curtain_status_leds #(.FLASH_CYCLES(FL), .ALIGN_CYCLES(AL)) light_curtain_status_leds_inst (
    .CLK(clk), .RST(rst), .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr), .SEL_I(4'hf), .DAT_I(dat_w),
    .DAT_O(dat_r), .ACK_O(ack), .CABLED(s.cabled), .FIELD_CLEAR(s.clr), .RESET_PENDING(s.pend),
    .RESET_PRESSED(s.press), .LASER_ON(s.laser), .FACTORY_RESTORE(s.fact), .CONFIG_MODE(s.cfg),
    .FEEDBACK_WARN(s.fwarn), .FEEDBACK_NO_SIGNAL(s.fnosig), .RESET_BTN_ERROR(s.berr),
    .RESET_BTN_DEFECT(s.bdef), .ALIGN_QUALITY(qual), .SYNC_TOP(s.top), .SYNC_BOTTOM(s.bot),
    .CONTAMINATION_UP(s.cont), .ALIGNING(s.algn), .SUPPLY_FAIL(s.sfail), .INTERNAL_FAULT(s.ifault),
    .RESTORE_FAIL(s.rfail), .OVERVOLTAGE(s.ovolt), .PROT_LED(prot), .FIELD_LED(field), .DIAG_LED(diag),
    .STATE_LED(state), .SENDER_FIELD_LED(sfield));
  for (genvar i = 0; i < 4; i++) begin : g_view
    led_viewer led_viewer_inst (.clk(clk), .clear(vclr), .led(vled[i]), .seen_on(von[i]), .seen_off(voff[i]),
      .lit(vlit[i]));
  end
  always #20 clk = ~clk;
  task automatic end_of_test;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_of_test
  always @(posedge clk) begin
    cyc_cnt++;
    if (cyc_cnt > 5000) begin
      error_cnt++;
      end_of_test;
    end
  end
  task automatic ck(input string n, input logic [2:0] e, input logic [2:0] g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %0h seen %0h", n, e, g);
    end
  endtask : ck
  task automatic pf(input led_status_pkg::colour_type ep, input led_status_pkg::colour_type ef);
    ck("prot led", ep, prot);
    ck("field led", ef, field);
  endtask : pf
  task automatic fl(input int i, input logic f, input led_status_pkg::colour_type c);
    ck("seen lit", 3'h1, {2'h0, von[i]});
    ck("seen dark", {2'h0, f}, {2'h0, voff[i]});
    ck("lit colour", c, vlit[i]);
  endtask : fl
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    {cyc, stb, we, adr, dat_w} <= {2'b11, w, a, d};
    do begin
      @(posedge clk);
      #1;
    end while (ack !== 1'b1);
    r = dat_r;
    @(posedge clk);
    {cyc, stb} <= 2'b00;
  endtask : wb
  task automatic go(input stat_type v);
    @(posedge clk);
    s <= v;
    repeat (2) @(posedge clk);
    #1;
  endtask : go
  task automatic view;
    @(posedge clk);
    vclr <= 1'b1;
    @(posedge clk);
    vclr <= 1'b0;
    repeat (10) @(posedge clk);
    #1;
  endtask : view
  task automatic t_regs;
    wb(1'b0, led_status_pkg::ADDR_CTRL, 32'h0000_0000, q);
    ck("ctrl reset", 3'h0, q[2:0]);
    wb(1'b0, 4'hc, 32'h0000_0000, q);
    ck("unmapped read", 3'h0, {2'h0, |q});
    go('{clr: 1'b1, top: 1'b1, default: 1'b0});
    for (int i = 0; i < 8; i++) ck("align", (i < 3 || i == 4 || i == 5) ? led_status_pkg::COL_BLUE : led_status_pkg::COL_OFF, diag[i]);
    wb(1'b1, led_status_pkg::ADDR_CTRL, 32'h0000_0007, q);
    wb(1'b0, led_status_pkg::ADDR_CTRL, 32'h0000_0000, q);
    ck("ctrl readback", 3'h7, q[2:0]);
    for (int k = 0; k < 3; k++) begin
      wb(1'b1, led_status_pkg::ADDR_CTRL, 32'h0000_000f, q);
      go('{clr: 1'b1, top: 1'b1, default: 1'b0});
      for (int i = 0; i < 4; i++) ck("functions", i == 1 ? led_status_pkg::COL_OFF : led_status_pkg::COL_WHITE, diag[i]);
      go('{clr: 1'b1, top: 1'b1, laser: (k == 0), cont: (k == 1), algn: (k == 2), default: 1'b0});
      repeat (AL + 4) @(posedge clk);
      #1;
      ck("resumed", led_status_pkg::COL_BLUE, diag[1]);
    end
  endtask : t_regs
  task automatic t_rx;
    go('{clr: 1'b1, pend: 1'b1, default: 1'b0});
    pf(led_status_pkg::COL_RED, led_status_pkg::COL_YELLOW);
    go('{clr: 1'b1, pend: 1'b1, press: 1'b1, default: 1'b0});
    pf(led_status_pkg::COL_RED, led_status_pkg::COL_RED);
    go('{default: 1'b0});
    pf(led_status_pkg::COL_RED, led_status_pkg::COL_RED);
    go('{clr: 1'b1, laser: 1'b1, default: 1'b0});
    pf(led_status_pkg::COL_RED, led_status_pkg::COL_GREEN);
    go('{cfg: 1'b1, default: 1'b0});
    pf(led_status_pkg::COL_RED, led_status_pkg::COL_GREEN);
    go('{fact: 1'b1, cfg: 1'b1, default: 1'b0});
    pf(led_status_pkg::COL_RED, led_status_pkg::COL_YELLOW_GREEN);
    for (int i = 0; i < 8; i++) ck("diag dark", led_status_pkg::COL_OFF, diag[i]);
  endtask : t_rx
  task automatic t_warn;
    go('{clr: 1'b1, fwarn: 1'b1, default: 1'b0});
    view;
    fl(2, 1'b1, led_status_pkg::COL_YELLOW);
    for (int i = 1; i < 4; i++) ck("align kept", led_status_pkg::COL_BLUE, diag[i]);
    go('{clr: 1'b1, berr: 1'b1, default: 1'b0});
    view;
    fl(3, 1'b1, led_status_pkg::COL_YELLOW);
    for (int i = 0; i < 3; i++) ck("align kept", led_status_pkg::COL_BLUE, diag[i]);
    go('{clr: 1'b1, bdef: 1'b1, default: 1'b0});
    view;
    fl(3, 1'b0, led_status_pkg::COL_YELLOW);
    go('{clr: 1'b1, fnosig: 1'b1, default: 1'b0});
    view;
    fl(2, 1'b0, led_status_pkg::COL_YELLOW);
    ck("prot led", led_status_pkg::COL_RED, prot);
  endtask : t_warn
  task automatic t_sender;
    go('{clr: 1'b1, default: 1'b0});
    ck("state", led_status_pkg::COL_YELLOW, state);
    ck("sender field", led_status_pkg::COL_OFF, sfield);
    go('{cabled: 1'b1, clr: 1'b1, pend: 1'b1, default: 1'b0});
    ck("state", led_status_pkg::COL_RED, state);
    ck("sender field", led_status_pkg::COL_YELLOW, sfield);
    go('{cabled: 1'b1, clr: 1'b1, default: 1'b0});
    ck("state", led_status_pkg::COL_GREEN, state);
    ck("sender field", led_status_pkg::COL_GREEN, sfield);
    go('{cabled: 1'b1, cfg: 1'b1, sfail: 1'b1, default: 1'b0});
    view;
    ck("state", led_status_pkg::COL_YELLOW, state);
    fl(0, 1'b1, led_status_pkg::COL_RED);
    go('{cabled: 1'b1, cfg: 1'b1, ifault: 1'b1, default: 1'b0});
    view;
    ck("state", led_status_pkg::COL_YELLOW, state);
    fl(0, 1'b1, led_status_pkg::COL_RED);
    go('{rfail: 1'b1, ifault: 1'b1, default: 1'b0});
    view;
    fl(1, 1'b1, led_status_pkg::COL_GREEN);
    fl(0, 1'b1, led_status_pkg::COL_RED);
    go('{ovolt: 1'b1, rfail: 1'b1, default: 1'b0});
    view;
    ck("state", led_status_pkg::COL_OFF, state);
    fl(0, 1'b0, led_status_pkg::COL_RED);
    wb(1'b0, led_status_pkg::ADDR_STATUS, 32'h0000_0000, q);
    ck("status fault", 3'h1, {2'h0, q[led_status_pkg::STAT_FAULT_BIT]});
    wb(1'b0, led_status_pkg::ADDR_LEDS, 32'h0000_0000, q);
    ck("leds state", led_status_pkg::COL_OFF, q[10:8]);
    ck("leds sender field", led_status_pkg::COL_RED, q[14:12]);
  endtask : t_sender
  initial begin
    {clk, cyc, stb, we, adr, dat_w, vclr} = '0;
    rst = 1'b1;
    s = '{clr: 1'b1, default: 1'b0};
    qual = 3'h3;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    @(posedge clk);
    qual <= 3'h4;
    t_rx;
    t_warn;
    t_sender;
    end_of_test;
  end
endmodule : test_light_curtain_status_leds
